// [asc_dev.sv]
/*
  converter end: calibration control, sequence table, trigger sync,
  single / repeat / scan sequencing, done flag, result register and a
  two-entry stream buffer toward dma.
  assumes an analog core that pulses core_done_i with core_data_i and
  core_cal_done_i with core_cal_i; trigger pins are asynchronous.
*/
`timescale 1ns/10ps
module asc_dev
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  asc_if.dev bus,
  input wire logic [ASC_TRIG_N-1:0] ext_trig_i,
  output logic core_power_down_o,
  output logic core_cal_start_o,
  input wire logic core_cal_done_i,
  input wire logic [ASC_CAL_W-1:0] core_cal_i,
  output logic [ASC_CAL_W-1:0] core_cal_o,
  output logic core_start_o,
  output logic [ASC_CH_W-1:0] core_channel_o,
  output asc_res_t core_res_o,
  input wire logic core_done_i,
  input wire logic [ASC_DW-1:0] core_data_i
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAL,
    ST_ARM,
    ST_WAIT
  } asc_dev_st_t;

  asc_dev_st_t state_q; // sequencer state
  logic [ASC_LEN_W-1:0] idx_q; // current slot
  logic [ASC_CH_W-1:0] slot_q [ASC_SLOTS]; // sequence table
  logic [ASC_CH_W-1:0] chan_q; // channel in flight
  logic [ASC_CAL_W-1:0] cal_q; // held calibration factor
  logic [ASC_DW-1:0] result_q; // result register
  logic done_q; // conversion-done flag
  logic [ASC_TRIG_N-1:0] s1_q, s2_q, s3_q; // trigger synchroniser
  logic [ASC_TRIG_N-1:0] lvl_q; // filtered trigger levels
  logic [ASC_DW-1:0] buf_q [ASC_BUF_DEPTH]; // stream buffer
  logic wp_q, rp_q; // buffer pointers
  logic [1:0] cnt_q; // buffer fill
  logic on; // converter switched on
  logic ext_edge; // selected trigger rose
  logic go; // conversion trigger
  logic room; // buffer can take a word
  logic conv_end; // core finished a word
  logic seq_last; // word is last of the pass
  logic push;

  assign on = bus.converter_on;
  assign conv_end = (state_q == ST_WAIT) && core_done_i;
  assign seq_last = !bus.scan_select || (idx_q == bus.sequence_length);
  // no dma: result register alone, so never stall
  assign room = !bus.dma_enable || (cnt_q != 2'(ASC_BUF_DEPTH));
  assign push = conv_end && bus.dma_enable;

  ////////////////////////////////////////////////////////////////////////
  // trigger pins: three flops, a change counts when stages 2 and 3 agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= ext_trig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // accept only settled values, filters single-cycle glitches
      for (int i = 0; i < ASC_TRIG_N; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  // rising edge of the selected, settled trigger
  assign ext_edge = bus.ext_trigger_enable &&
    s2_q[bus.ext_trigger_select] && s3_q[bus.ext_trigger_select] &&
    !lvl_q[bus.ext_trigger_select];
  // triggers ignored unless idle, so calibration blocks them
  assign go = on && (state_q == ST_IDLE) &&
    (bus.soft_trigger || ext_edge);

  ////////////////////////////////////////////////////////////////////////
  // sequence table writes; table survives power-down like config bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ASC_SLOTS; i++) begin
        slot_q[i] <= ASC_SLOT_RST;
      end
    end else if (bus.slot_we) begin
      slot_q[bus.slot_idx] <= bus.slot_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: calibration, then single, repeat or scan passes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      idx_q <= ASC_LEN_RST;
      chan_q <= ASC_SLOT_RST;
    end else if (!on) begin
      state_q <= ST_IDLE;
      idx_q <= ASC_LEN_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bus.calibrate_start) begin
            state_q <= ST_CAL;
          end else if (go) begin
            idx_q <= ASC_LEN_RST;
            state_q <= ST_ARM;
          end
        end
        ST_CAL: begin
          if (core_cal_done_i) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ARM: begin
          // hold off while the buffer is full so no word is lost
          if (room) begin
            chan_q <= slot_q[idx_q];
            state_q <= ST_WAIT;
          end
        end
        default: begin
          if (core_done_i) begin
            if (!seq_last) begin
              idx_q <= idx_q + 4'h1;
              state_q <= ST_ARM;
            end else if (bus.repeat_mode) begin
              idx_q <= ASC_LEN_RST;
              state_q <= ST_ARM;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration factor: kept across conversions, lost at power-off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_q <= ASC_CAL_RST;
    end else if (!on || bus.calibration_reset) begin
      cal_q <= ASC_CAL_RST;
    end else if ((state_q == ST_CAL) && core_cal_done_i) begin
      cal_q <= core_cal_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result register and done flag; a set beats a same-cycle clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_q <= ASC_DATA_RST;
      done_q <= 1'b0;
    end else if (!on) begin
      done_q <= 1'b0;
    end else begin
      if (conv_end) begin
        result_q <= asc_mask(bus.resolution, core_data_i);
      end
      if (conv_end && seq_last) begin
        done_q <= 1'b1;
      end else if (bus.done_clr) begin
        done_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry stream buffer feeding the dma party
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      for (int i = 0; i < ASC_BUF_DEPTH; i++) begin
        buf_q[i] <= ASC_DATA_RST;
      end
    end else if (!on) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= asc_mask(bus.resolution, core_data_i);
        wp_q <= !wp_q;
      end
      if (bus.dma_ack && bus.dma_req) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(bus.dma_ack && bus.dma_req);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to host and to the analog core
  assign bus.calibrate_busy = (state_q == ST_CAL);
  assign bus.done_flag = done_q;
  assign bus.irq = done_q && bus.done_irq_enable;
  assign bus.result = result_q;
  assign bus.dma_req = (cnt_q != 2'h0);
  assign bus.dma_data = buf_q[rp_q];
  assign core_power_down_o = !on;
  assign core_cal_start_o = on && (state_q == ST_IDLE) &&
    bus.calibrate_start;
  assign core_cal_o = cal_q;
  assign core_start_o = (state_q == ST_ARM) && room;
  assign core_channel_o = (state_q == ST_ARM) ? slot_q[idx_q] : chan_q;
  assign core_res_o = bus.resolution;
endmodule

// [asc_pkg.sv]
/*
  shared constants and types for the converter sequence control block:
  slot table size, field widths, reset values and cycle counts.
  assumes both ends run on one clock, clk_i, at 250 MHz.
*/
package asc_pkg;
  // sequence table and field widths
  localparam int ASC_SLOTS = 16;
  localparam int ASC_LEN_W = 4;
  localparam int ASC_CH_W = 5;
  localparam int ASC_DW = 12;
  localparam int ASC_CAL_W = 8;
  localparam int ASC_TRIG_N = 8;
  localparam int ASC_TSEL_W = 3;
  // two-entry result buffer
  localparam int ASC_BUF_DEPTH = 2;
  // converter settle time before calibration, in converter clocks
  localparam int ASC_SETTLE_CYC = 14;
  localparam logic [3:0] ASC_SETTLE_LAST = 4'(ASC_SETTLE_CYC - 1);
  // reset values
  localparam logic [ASC_CH_W-1:0] ASC_SLOT_RST = 5'h00;
  localparam logic [ASC_DW-1:0] ASC_DATA_RST = 12'h000;
  localparam logic [ASC_CAL_W-1:0] ASC_CAL_RST = 8'h00;
  localparam logic [ASC_LEN_W-1:0] ASC_LEN_RST = 4'h0;

  // resolution select, order gives codes 0..3
  typedef enum logic [1:0] {
    ASC_RES12,
    ASC_RES10,
    ASC_RES8,
    ASC_RES6
  } asc_res_t;

  // keep only the bits a given resolution produces
  function automatic logic [ASC_DW-1:0] asc_mask(
    input asc_res_t res,
    input logic [ASC_DW-1:0] d
  );
    logic [ASC_DW-1:0] m;
    m = 12'hFFF;
    case (res)
      ASC_RES10: m = 12'h3FF;
      ASC_RES8: m = 12'h0FF;
      ASC_RES6: m = 12'h03F;
      default: m = 12'hFFF;
    endcase
    return d & m;
  endfunction
endpackage

// [asc_if.sv]
/*
  control and status wires between the software or dma party and the
  converter control logic. levels are held by the host; *_clr
  and soft_trigger are one-cycle pulses.
  assumes both ends share clk_i and rst_i.
*/
`timescale 1ns/10ps
interface asc_if
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i
);
  logic converter_on; // enable switch
  logic calibrate_start; // pulse: launch calibration
  logic calibration_reset; // pulse: drop held calibration
  logic calibrate_busy; // reads as the calibrate-start bit
  logic scan_select;
  logic repeat_mode;
  logic piecewise_select; // not supported, kept low by host
  logic dma_enable;
  logic done_irq_enable;
  logic soft_trigger; // pulse
  logic ext_trigger_enable;
  logic [ASC_TSEL_W-1:0] ext_trigger_select;
  logic [ASC_LEN_W-1:0] sequence_length;
  asc_res_t resolution;
  logic slot_we; // pulse: write one slot
  logic [ASC_LEN_W-1:0] slot_idx;
  logic [ASC_CH_W-1:0] slot_chan;
  logic done_flag; // conversion-done
  logic done_clr; // pulse: software writes 0
  logic irq;
  logic [ASC_DW-1:0] result; // result register
  logic dma_req; // stream word waiting
  logic [ASC_DW-1:0] dma_data;
  logic dma_ack; // stream word taken

  modport host (
    output converter_on, calibrate_start, calibration_reset,
    output scan_select, repeat_mode, piecewise_select, dma_enable,
    output done_irq_enable, soft_trigger, ext_trigger_enable,
    output ext_trigger_select, sequence_length, resolution,
    output slot_we, slot_idx, slot_chan, done_clr, dma_ack,
    input calibrate_busy, done_flag, irq, result, dma_req, dma_data
  );
  modport dev (
    input converter_on, calibrate_start, calibration_reset,
    input scan_select, repeat_mode, piecewise_select, dma_enable,
    input done_irq_enable, soft_trigger, ext_trigger_enable,
    input ext_trigger_select, sequence_length, resolution,
    input slot_we, slot_idx, slot_chan, done_clr, dma_ack,
    output calibrate_busy, done_flag, irq, result, dma_req, dma_data
  );
endinterface

// [asc_host.sv]
/*
  software / dma end: turns user commands into the control wires,
  enforces the settle delay and calibration order, reads the result a
  cycle after done and clears the flag, and drains the stream buffer.
  assumes the converter end of asc_if on the same clock.
*/
`timescale 1ns/10ps
module asc_host
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  asc_if.host bus,
  input wire logic cfg_on_i,
  input wire logic cfg_scan_i,
  input wire logic cfg_repeat_i,
  input wire logic cfg_dma_i,
  input wire logic cfg_irq_en_i,
  input wire logic cfg_ext_en_i,
  input wire logic [ASC_TSEL_W-1:0] cfg_ext_sel_i,
  input wire logic [ASC_LEN_W-1:0] cfg_len_i,
  input wire logic [1:0] cfg_res_i,
  input wire logic slot_we_i,
  input wire logic [ASC_LEN_W-1:0] slot_idx_i,
  input wire logic [ASC_CH_W-1:0] slot_chan_i,
  input wire logic cal_req_i,
  input wire logic cal_reset_i,
  input wire logic trig_req_i,
  output logic ready_o,
  output logic cal_busy_o,
  output logic rd_valid_o,
  output logic [ASC_DW-1:0] rd_data_o,
  output logic irq_o,
  output logic st_valid_o,
  output logic [ASC_DW-1:0] st_data_o,
  input wire logic st_ready_i
);
  logic [3:0] settle_q; // clocks since switch-on
  logic settled;
  logic cal_q; // calibration in progress
  logic rd_wait_q; // one-clock wait after done
  logic [ASC_DW-1:0] rd_q;
  logic rd_v_q;
  logic idle;

  ////////////////////////////////////////////////////////////////////////
  // settle counter after switch-on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= 4'h0;
    end else if (!cfg_on_i) begin
      settle_q <= 4'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 4'h1;
    end
  end
  assign settled = (settle_q > ASC_SETTLE_LAST);

  ////////////////////////////////////////////////////////////////////////
  // calibration: start, then poll the busy bit until it drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_q <= 1'b0;
    end else if (!cfg_on_i) begin
      cal_q <= 1'b0;
    end else if (bus.calibrate_start) begin
      cal_q <= 1'b1;
    end else if (cal_q && !bus.calibrate_busy) begin
      cal_q <= 1'b0;
    end
  end
  // a new command waits for settle and for calibration to end
  assign idle = cfg_on_i && settled && !cal_q && !bus.calibrate_busy;
  assign bus.calibrate_start = idle && cal_req_i;
  assign bus.calibration_reset = idle && cal_reset_i;
  assign bus.soft_trigger = idle && trig_req_i && !cal_req_i;

  ////////////////////////////////////////////////////////////////////////
  // result read one clock after done, flag cleared in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_wait_q <= 1'b0;
      rd_q <= ASC_DATA_RST;
      rd_v_q <= 1'b0;
    end else begin
      rd_v_q <= 1'b0;
      rd_wait_q <= bus.done_flag && !rd_wait_q;
      if (rd_wait_q) begin
        rd_q <= bus.result;
        rd_v_q <= 1'b1;
      end
    end
  end
  assign bus.done_clr = rd_wait_q;

  ////////////////////////////////////////////////////////////////////////
  // configuration levels
  assign bus.converter_on = cfg_on_i;
  assign bus.scan_select = cfg_scan_i;
  assign bus.repeat_mode = cfg_repeat_i;
  assign bus.piecewise_select = 1'b0;
  assign bus.dma_enable = cfg_dma_i || cfg_scan_i;
  assign bus.done_irq_enable = cfg_irq_en_i;
  assign bus.ext_trigger_enable = cfg_ext_en_i;
  assign bus.ext_trigger_select = cfg_ext_sel_i;
  assign bus.sequence_length = cfg_len_i;
  assign bus.resolution = asc_res_t'(cfg_res_i);
  assign bus.slot_we = slot_we_i;
  assign bus.slot_idx = slot_idx_i;
  assign bus.slot_chan = slot_chan_i;
  assign bus.dma_ack = st_ready_i;

  ////////////////////////////////////////////////////////////////////////
  // user outputs
  assign ready_o = idle;
  assign cal_busy_o = cal_q || bus.calibrate_busy;
  assign rd_valid_o = rd_v_q;
  assign rd_data_o = rd_q;
  assign irq_o = bus.irq;
  assign st_valid_o = bus.dma_req;
  assign st_data_o = bus.dma_data;
endmodule

// [asc_chk.sv]
/*
  assertion checker on the wires between host and converter ends.
  assumes one clock, clk_i, and the active-high reset rst_i.
*/
`timescale 1ns/10ps
module asc_chk
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic converter_on,
  input wire logic calibrate_start,
  input wire logic calibrate_busy,
  input wire logic scan_select,
  input wire logic dma_enable,
  input wire logic done_irq_enable,
  input wire logic soft_trigger,
  input wire logic done_flag,
  input wire logic done_clr,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic [ASC_DW-1:0] dma_data,
  input wire logic dma_ack
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // settle counter: edges seen with the converter on, saturating
  logic [3:0] on_cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt_q <= 4'h0;
    end else if (!converter_on) begin
      on_cnt_q <= 4'h0; // switch-off restarts the settle wait
    end else if (on_cnt_q != 4'hF) begin
      on_cnt_q <= on_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calibration launch in two steps: idle request, then busy
  sequence s_cal_req;
    calibrate_start && converter_on && !calibrate_busy && !done_flag;
  endsequence
  sequence s_cal_run;
    calibrate_busy [*2];
  endsequence
  property p_cal_go;
    s_cal_req |=> s_cal_run;
  endproperty
  property p_cal_src;
    $rose(calibrate_busy) |-> $past(calibrate_start);
  endproperty
  // counter holds the edges already seen with the converter on
  property p_settle;
    (calibrate_start || soft_trigger) |-> on_cnt_q >= ASC_SETTLE_CYC;
  endproperty
  property p_off;
    !converter_on |=> !calibrate_busy && !done_flag && !dma_req;
  endproperty
  property p_irq;
    irq == (done_flag && done_irq_enable);
  endproperty
  property p_clr;
    $fell(done_flag) |-> $past(done_clr) || !$past(converter_on);
  endproperty
  property p_scan_dma;
    scan_select |-> dma_enable;
  endproperty
  // a waiting word must not move or vanish before it is taken
  property p_hold;
    dma_req && !dma_ack && converter_on |=> dma_req && $stable(dma_data);
  endproperty

  a_cal_go: assert property (p_cal_go)
    else $error("calibration did not start");
  a_cal_src: assert property (p_cal_src)
    else $error("busy without a start");
  a_settle: assert property (p_settle)
    else $error("command before settle time");
  a_off: assert property (p_off)
    else $error("state kept while off");
  a_irq: assert property (p_irq)
    else $error("irq does not follow done and enable");
  a_clr: assert property (p_clr)
    else $error("done flag dropped without clear");
  a_scan_dma: assert property (p_scan_dma)
    else $error("scan without stream transfer");
  a_hold: assert property (p_hold)
    else $error("stream word lost before taken");
endmodule

// [tb_adc_sequence_control.sv]
/*
  bench: host and converter ends joined by asc_if, a core stand-in,
  single conversions from a table, then hand tests.
  assumes the package constants and a 250 MHz clock.
*/
`timescale 1ns/10ps
module tb_adc_sequence_control
  import asc_pkg::*;
();
  typedef struct packed {
    logic [4:0] ch;
    logic [1:0] res;
    logic ie;
    logic [11:0] mask;
  } asc_row_t;
  // slot channel, resolution code, irq enable, bits that survive
  localparam asc_row_t ROWS [4] = '{
    '{5'h01, 2'h0, 1'b1, 12'hFFF}, '{5'h0A, 2'h1, 1'b0, 12'h3FF},
    '{5'h13, 2'h2, 1'b1, 12'h0FF}, '{5'h1F, 2'h3, 1'b0, 12'h03F}};
  localparam logic [4:0] SCAN [3] = '{5'h03, 5'h09, 5'h1C};
  logic clk_i, rst_i;
  logic on, scan, rpt, dma, ie, ext_en, we, cal_req, cal_rst, trig, st_rdy;
  logic [2:0] ext_sel;
  logic [3:0] len, idx;
  logic [4:0] chan, core_ch, ch_q;
  logic [1:0] res;
  logic [7:0] ext, cal_o;
  logic ready, cal_busy, rd_valid, irq, st_valid, pdn, cal_go;
  logic core_start, cal_done, core_done, saw_irq;
  logic cal_seen = 1'b0; // calibration pulse caught at a rising edge
  logic [11:0] rd_data, st_data, core_data;
  asc_res_t core_res;
  logic [11:0] words [$]; // stream words taken by the bench
  int num_errors, n_tests, n_starts, s0, conv_cnt, cal_cnt;

  asc_if asc_if_i (.clk_i(clk_i), .rst_i(rst_i));
  asc_dev asc_dev_i (.clk_i(clk_i), .rst_i(rst_i), .bus(asc_if_i.dev),
    .ext_trig_i(ext), .core_power_down_o(pdn), .core_cal_start_o(cal_go),
    .core_cal_done_i(cal_done), .core_cal_i(8'h5A), .core_cal_o(cal_o),
    .core_start_o(core_start), .core_channel_o(core_ch),
    .core_res_o(core_res), .core_done_i(core_done),
    .core_data_i(core_data));
  asc_host asc_host_i (.clk_i(clk_i), .rst_i(rst_i), .bus(asc_if_i.host),
    .cfg_on_i(on), .cfg_scan_i(scan), .cfg_repeat_i(rpt), .cfg_dma_i(dma),
    .cfg_irq_en_i(ie), .cfg_ext_en_i(ext_en), .cfg_ext_sel_i(ext_sel),
    .cfg_len_i(len), .cfg_res_i(res), .slot_we_i(we), .slot_idx_i(idx),
    .slot_chan_i(chan), .cal_req_i(cal_req), .cal_reset_i(cal_rst),
    .trig_req_i(trig), .ready_o(ready), .cal_busy_o(cal_busy),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .irq_o(irq),
    .st_valid_o(st_valid), .st_data_o(st_data), .st_ready_i(st_rdy));
  asc_chk asc_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .converter_on(asc_if_i.converter_on),
    .calibrate_start(asc_if_i.calibrate_start),
    .calibrate_busy(asc_if_i.calibrate_busy),
    .scan_select(asc_if_i.scan_select), .dma_enable(asc_if_i.dma_enable),
    .done_irq_enable(asc_if_i.done_irq_enable),
    .soft_trigger(asc_if_i.soft_trigger), .done_flag(asc_if_i.done_flag),
    .done_clr(asc_if_i.done_clr), .irq(asc_if_i.irq),
    .dma_req(asc_if_i.dma_req), .dma_data(asc_if_i.dma_data),
    .dma_ack(asc_if_i.dma_ack));

  ////////////////////////////////////////////////////////////////////////
  // core stand-in: 3-cycle conversion, 5-cycle calibration
  always @(negedge clk_i) begin
    core_done = 1'b0;
    cal_done = 1'b0;
    core_data = ~core_data; // data only valid in the three counting cycles up to done
    if (core_start === 1'b1) begin
      n_starts++;
      ch_q = core_ch;
      conv_cnt = 3;
    end else if (conv_cnt > 0) begin
      conv_cnt--;
      core_done = (conv_cnt == 0);
      core_data = {ch_q, 7'h43}; // channel shows in the word
    end
    // the start pulse only stands until the next rising edge
    if (cal_seen === 1'b1) begin
      cal_seen = 1'b0;
      cal_cnt = 5;
    end else if (cal_cnt > 0) begin
      cal_cnt--;
      cal_done = (cal_cnt == 0);
    end
  end
  // stream sink and irq watch, seen before the edge's updates land
  always @(posedge clk_i) begin
    if (st_valid === 1'b1 && st_rdy)
      words.push_back(st_data);
    if (irq === 1'b1)
      saw_irq = 1'b1;
    if (cal_go === 1'b1)
      cal_seen = 1'b1;
  end

  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({11'h000, got}, {11'h000, exp});
  endtask
  task automatic put_slot(input logic [3:0] i, input logic [4:0] c);
    {we, idx, chan} = {1'b1, i, c};
    @(negedge clk_i);
    we = 1'b0;
    // one idle cycle so a following write never re-raises we at once
    @(negedge clk_i);
  endtask
  task automatic pulse_trig();
    trig = 1'b1;
    @(negedge clk_i);
    trig = 1'b0;
  endtask
  task automatic wait_rd();
    int i;
    for (i = 0; i < 300 && rd_valid !== 1'b1; i++)
      @(negedge clk_i);
    chk_bit(rd_valid, 1'b1);
  endtask
  task automatic wait_words(input int n);
    int i;
    for (i = 0; i < 400 && words.size() < n; i++)
      @(negedge clk_i);
    chk_bit(words.size() >= n, 1'b1);
  endtask
  task automatic power_up();
    int i;
    on = 1'b1;
    for (i = 0; i < 40 && ready !== 1'b1; i++)
      @(negedge clk_i);
    chk_bit(i >= 14, 1'b1);
    chk_bit(pdn, 1'b0);
  endtask
  task automatic calibrate();
    int i;
    cal_req = 1'b1;
    @(negedge clk_i);
    cal_req = 1'b0;
    for (i = 0; i < 9 && cal_busy !== 1'b1; i++)
      @(negedge clk_i);
    chk_bit(cal_busy, 1'b1);
    for (i = 0; i < 50 && cal_busy !== 1'b0; i++)
      @(negedge clk_i);
    chk_bit(cal_busy, 1'b0);
    chk_word({4'h0, cal_o}, 12'h05A);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    num_errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    {on, scan, rpt, dma, ie, ext_en, we, cal_req, cal_rst, trig} = '0;
    {st_rdy, ext_sel, len, idx, chan, res, ext, core_data} = '0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk_bit(ready, 1'b0);
    chk_bit(pdn, 1'b1);
    power_up();
    calibrate();
    $display("test power-up and calibration done");
    foreach (ROWS[k]) begin
      {res, ie, saw_irq} = {ROWS[k].res, ROWS[k].ie, 1'b0};
      put_slot(4'h0, ROWS[k].ch);
      s0 = n_starts;
      pulse_trig();
      wait_rd();
      chk_word(rd_data, {ROWS[k].ch, 7'h43} & ROWS[k].mask);
      chk_word({10'h000, core_res}, {10'h000, ROWS[k].res});
      chk_bit(saw_irq, ROWS[k].ie);
      chk_bit(asc_if_i.done_flag, 1'b0);
      repeat (12) @(negedge clk_i);
      chk_word(12'(n_starts - s0), 12'h001);
    end
    $display("test single table done");
    {ext_en, ext_sel, ext, s0} = {1'b1, 3'h2, 8'h20, n_starts};
    repeat (12) @(negedge clk_i);
    chk_word(12'(n_starts - s0), 12'h000);
    ext = 8'h24; // selected pin rises and stays high
    wait_rd();
    repeat (20) @(negedge clk_i);
    chk_word(12'(n_starts - s0), 12'h001);
    {ext, ext_en, res} = '0;
    $display("test hardware trigger done");
    foreach (SCAN[k])
      put_slot(4'(k), SCAN[k]);
    {len, scan, s0} = {4'h2, 1'b1, n_starts};
    pulse_trig();
    repeat (40) @(negedge clk_i);
    chk_word(12'(n_starts - s0), 12'h002);
    chk_bit(asc_if_i.done_flag, 1'b0);
    st_rdy = 1'b1; // far side stops stalling
    wait_rd();
    chk_word(rd_data, {SCAN[2], 7'h43});
    foreach (SCAN[k])
      chk_word(words[k], {SCAN[k], 7'h43});
    $display("test scan with stall done");
    words.delete();
    rpt = 1'b1;
    pulse_trig();
    wait_words(5);
    rpt = 1'b0;
    chk_word(words[3], {SCAN[0], 7'h43});
    chk_word(words[4], {SCAN[1], 7'h43});
    repeat (60) @(negedge clk_i);
    $display("test scan repeat done");
    words.delete();
    {scan, rpt, dma} = 3'b011;
    put_slot(4'h0, 5'h06);
    pulse_trig();
    wait_words(3);
    rpt = 1'b0;
    for (int k = 0; k < 3; k++)
      chk_word(words[k], {5'h06, 7'h43});
    repeat (40) @(negedge clk_i);
    $display("test single repeat done");
    chk_word({4'h0, cal_o}, 12'h05A);
    on = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_word({4'h0, cal_o}, 12'h000);
    chk_bit(pdn, 1'b1);
    power_up();
    calibrate();
    cal_rst = 1'b1;
    @(negedge clk_i);
    cal_rst = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_word({4'h0, cal_o}, 12'h000);
    $display("test power-off and calibration reset done");
    end_of_test();
  end
endmodule
